// file: rtl/dual_adc_path.sv
// Purpose: Digital data path of a dual ten-bit pipelined converter
// Assumes: Stage decisions arrive as digital codes on SAMPLE_*_I, already on REF_CLK_I
// Notes: Stage codes stand in for the analog core; a FIFO and a pin register follow correction
`timescale 1ns/1ps
module dual_adc_path
	import adc_path_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	input wire logic [adc_path_pkg::RESULT_W-1:0] SAMPLE_I_I,
	input wire logic [adc_path_pkg::RESULT_W-1:0] SAMPLE_Q_I,
	output logic [adc_path_pkg::RESULT_W-1:0] RESULT_I_O,
	output logic [adc_path_pkg::RESULT_W-1:0] RESULT_Q_O,
	output logic RESULT_VALID_O,
	input wire logic RESULT_READY_I,
	output logic SAMPLE_READY_O,
	output logic INIT_DONE_O
);
	import adc_path_pkg::*;

	// Ideal stage decisions per channel; a real core would supply the flash codes
	typedef logic [STAGE_N-1:0][STAGE_W-1:0] stage_words_t;
	typedef struct packed {
		logic phase_hold;
		logic [RESULT_W-1:0] held_i;
		logic [RESULT_W-1:0] held_q;
		logic [ALIGN_DEPTH-1:0][ALIGNED_W-1:0] line_i;
		logic [ALIGN_DEPTH-1:0][ALIGNED_W-1:0] line_q;
		logic [ALIGN_DEPTH-1:0] line_v;
		logic [RESULT_W-1:0] out_i;
		logic [RESULT_W-1:0] out_q;
		logic out_v;
		logic [4:0] init_cnt;
		logic init_done;
	} path_state_t;

	path_state_t q;
	path_state_t next_q;
	logic fifo_in_ready;
	logic [FIFO_W-1:0] fifo_out_data;
	logic fifo_out_valid;
	logic out_taken;
	logic [ALIGNED_W-1:0] raw_i;
	logic [ALIGNED_W-1:0] raw_q;
	logic [FIFO_W-1:0] pin_data;
	logic pin_valid;
	logic pin_ready;
	logic pin_ready_r;
	logic pin_init;

	// Split a code into eight redundant stage words plus a final two-bit word
	function automatic logic [ALIGNED_W-1:0] split_stages(input logic [RESULT_W-1:0] code);
		logic [ALIGNED_W-1:0] w;
		w = '0;
		for (int s = 0; s < STAGE_N - 1; s++)
			w[ALIGNED_W-1-2*s -: 2] = {1'b0, code[RESULT_W-1-s]};
		w[1:0] = code[1:0];
		return w;
	endfunction : split_stages

	// Overlap-add of stage words: each stage weighs one bit less than the last, the final two-bit word two bits less
	function automatic logic [RESULT_W-1:0] correct(input logic [ALIGNED_W-1:0] w);
		logic [RESULT_W+1:0] acc;
		acc = '0;
		for (int s = 0; s < STAGE_N - 1; s++)
			acc = acc + ((RESULT_W+2)'(w[ALIGNED_W-1-2*s -: 2]) << (RESULT_W - 1 - s));
		acc = acc + (RESULT_W+2)'(w[1:0]);
		// Saturate so redundancy overflow pins to positive full scale
		if (acc[RESULT_W+1:RESULT_W] != 2'b00)
			return {RESULT_W{1'b1}};
		return acc[RESULT_W-1:0];
	endfunction : correct

	assign raw_i = split_stages(q.held_i);
	assign raw_q = split_stages(q.held_q);
	assign out_taken = q.out_v && fifo_in_ready;

	// Pipeline advances every cycle; a full FIFO drops the newest word
	always_comb
	begin
		next_q = q;
		next_q.phase_hold = ~q.phase_hold;
		next_q.held_i = SAMPLE_I_I;
		next_q.held_q = SAMPLE_Q_I;
		next_q.line_i = {q.line_i[ALIGN_DEPTH-2:0], raw_i};
		next_q.line_q = {q.line_q[ALIGN_DEPTH-2:0], raw_q};
		next_q.line_v = {q.line_v[ALIGN_DEPTH-2:0], q.init_done};
		next_q.out_i = correct(q.line_i[ALIGN_DEPTH-1]);
		next_q.out_q = correct(q.line_q[ALIGN_DEPTH-1]);
		next_q.out_v = q.line_v[ALIGN_DEPTH-1];
		if (!q.init_done)
		begin
			next_q.init_cnt = q.init_cnt + 5'h01;
			if (q.init_cnt == INIT_CNT_W5 - 5'h01)
				next_q.init_done = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			q <= '0;
		else
			q <= next_q;
	end

	// Output buffer decouples capture logic stalls from the pipeline
	word_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_out_fifo (
		.REF_CLK_I(REF_CLK_I),
		.RESET_I(RESET_I),
		.in_data_i({q.out_i, q.out_q}),
		.in_valid_i(q.out_v),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pin_ready) // Pop only when the pin stage loads, else a word shows twice
	);

	// Registered outputs: one-word skid stage in front of the pins
	assign pin_ready = !pin_valid || RESULT_READY_I;
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
		begin
			pin_data <= '0;
			pin_valid <= 1'b0;
			pin_ready_r <= 1'b0;
			pin_init <= 1'b0;
		end
		else
		begin
			if (pin_ready)
			begin
				pin_data <= fifo_out_data;
				pin_valid <= fifo_out_valid;
			end
			pin_ready_r <= fifo_in_ready;
			pin_init <= q.init_done;
		end
	end
	assign RESULT_I_O = pin_data[FIFO_W-1:RESULT_W];
	assign RESULT_Q_O = pin_data[RESULT_W-1:0];
	assign RESULT_VALID_O = pin_valid;
	assign SAMPLE_READY_O = pin_ready_r;
	assign INIT_DONE_O = pin_init;

	// Fixed six-cycle latency from sample pins to corrected word register
	logic [LATENCY_CYC:0] lat_cnt;
	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			lat_cnt <= '0;
		else
			lat_cnt <= {lat_cnt[LATENCY_CYC-1:0], 1'b1};
	end

	property p_latency;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[LATENCY_CYC] |-> q.out_i == correct(split_stages($past(SAMPLE_I_I, 6)));
	endproperty
	a_latency: assert property (p_latency) else $error("I word latency wrong");

	property p_latency_q;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[LATENCY_CYC] |-> q.out_q == $past(SAMPLE_Q_I, 6);
	endproperty
	a_latency_q: assert property (p_latency_q) else $error("Q word latency or code wrong");

	property p_stream;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		q.line_v[ALIGN_DEPTH-1] |=> q.out_v;
	endproperty
	a_stream: assert property (p_stream) else $error("word not produced each cycle");

	property p_msb;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[LATENCY_CYC] |-> q.out_i[RESULT_W-1] == ($past(SAMPLE_I_I, 6) >= MIDSCALE);
	endproperty
	a_msb: assert property (p_msb) else $error("msb disagrees with midscale");

	property p_phase;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[0] |=> q.phase_hold != $past(q.phase_hold);
	endproperty
	a_phase: assert property (p_phase) else $error("phases overlap");

	property p_init;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		$rose(q.init_done) |-> q.init_cnt == INIT_CNT_W5;
	endproperty
	a_init: assert property (p_init) else $error("init window wrong length");

	property p_fullscale;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[LATENCY_CYC] && $past(SAMPLE_I_I, 6) == {RESULT_W{1'b1}} |-> &q.out_i;
	endproperty
	a_fullscale: assert property (p_fullscale) else $error("full scale code wrong");

	// Last delay tap must hold the first and final stage words of one sample
	property p_align;
		@(posedge REF_CLK_I) disable iff (RESET_I)
		lat_cnt[LATENCY_CYC-1] |-> (q.line_i[ALIGN_DEPTH-1][1:0] == $past(SAMPLE_I_I[1:0], 5))
			&& (q.line_i[ALIGN_DEPTH-1][ALIGNED_W-2] == $past(SAMPLE_I_I[RESULT_W-1], 5));
	endproperty
	a_align: assert property (p_align) else $error("stage words not aligned");

	c_first: cover property (@(posedge REF_CLK_I) $rose(q.out_v));
	c_full: cover property (@(posedge REF_CLK_I) !fifo_in_ready);
	c_top: cover property (@(posedge REF_CLK_I) &q.out_i);
endmodule : dual_adc_path

// file: rtl/adc_path_pkg.sv
// Purpose: Shared constants for the dual pipelined converter data path
// Assumes: One 50 MHz sampling clock, synchronous active-high reset
// Notes: Stage words are two bits; eighteen-bit aligned word feeds correction
package adc_path_pkg;
	localparam int RESULT_W = 10;
	localparam int STAGE_W = 2;
	localparam int STAGE_N = 9;
	localparam int ALIGNED_W = 18;
	localparam int LATENCY_CYC = 6;
	localparam int INIT_CYC = 20;
	localparam int FIFO_W = 2 * RESULT_W;
	localparam int FIFO_D = 32;
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic [9:0] MIDSCALE = 10'h200;
	localparam logic [4:0] INIT_CNT_W5 = 5'h14;
	localparam logic [3:0] ALIGN_DEPTH = 4'h4;
endpackage : adc_path_pkg

// file: rtl/word_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 32
) (
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_state_t;
	fifo_state_t q;
	fifo_state_t next_q;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// Handshakes only when room or data exists
	assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (q.cnt != '0);
	assign out_data_o = mem[q.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb
	begin
		next_q = q;
		if (push)
			next_q.wr = q.wr + 1'b1;
		if (pop)
			next_q.rd = q.rd + 1'b1;
		if (push && !pop)
			next_q.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			next_q.cnt = q.cnt - 1'b1;
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (RESET_I)
			q <= '0;
		else
			q <= next_q;
	end

	// Storage has no reset, so it maps onto plain RAM
	always_ff @(posedge REF_CLK_I)
	begin
		if (push)
			mem[q.wr] <= in_data_i;
	end
endmodule : word_fifo

// file: test/capture_model.sv
// Purpose: Capture logic reading both result buses
// Assumes: Shares the sampling clock with the data path
// Notes: Ready is the inverse of stall_i, one edge late
`timescale 1ns/1ps
module capture_model
	import adc_path_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic [adc_path_pkg::RESULT_W-1:0] res_i_i,
	input wire logic [adc_path_pkg::RESULT_W-1:0] res_q_i,
	input wire logic valid_i,
	output logic ready_o
);
	logic [adc_path_pkg::FIFO_W-1:0] rx_q[$];
	int age;
	// Early words ignored, both buses on one edge
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			age <= 0;
			ready_o <= 1'b0;
		end
		else
		begin
			age <= age + 1;
			ready_o <= !stall_i;
			if (valid_i && ready_o && age > INIT_CYC)
				rx_q.push_back({res_i_i, res_q_i});
		end
	end
endmodule : capture_model

// file: test/dual_adc_path_tb.sv
// Purpose: Self-checking bench for the dual converter path
// Assumes: Result word equals the ideal code of its sample
// Notes: Drops show as gaps when matching the stream in order
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("Error %0t: %h vs %h", $time, a, e); end end
module dual_adc_path_tb;
	import adc_path_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic stall = 1'b0;
	logic hold = 1'b0;
	logic jitter = 1'b0;
	logic s_low = 1'b0;
	logic [9:0] smp_i = 10'h155;
	logic [9:0] smp_q = 10'h2AA;
	logic [9:0] res_i;
	logic [9:0] res_q;
	logic vld;
	logic rdy;
	logic s_rdy;
	logic init_done;
	logic [19:0] got;
	logic [19:0] exp_q[$];
	int bad_count = 0;
	int num_checks = 0;
	int seed = 41436;
	int cyc = 0;
	int skips = 0;
	int lat = 0;
	dual_adc_path i_dut (.REF_CLK_I(clk), .RESET_I(rst), .SAMPLE_I_I(smp_i), .SAMPLE_Q_I(smp_q),
		.RESULT_I_O(res_i), .RESULT_Q_O(res_q), .RESULT_VALID_O(vld), .RESULT_READY_I(rdy),
		.SAMPLE_READY_O(s_rdy), .INIT_DONE_O(init_done));
	capture_model i_cap (.clk_i(clk), .rst_i(rst), .stall_i(stall), .res_i_i(res_i), .res_q_i(res_q),
		.valid_i(vld), .ready_o(rdy));
	function automatic logic [19:0] exp_word(input logic [9:0] a, input logic [9:0] b);
		return {a, b};
	endfunction : exp_word
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// One sample pair per edge; the idle pad is never expected back
	task automatic send(input logic [9:0] a, input logic [9:0] b);
		@(posedge clk);
		if (s_rdy === 1'b0)
			s_low = 1'b1;
		smp_i <= a;
		smp_q <= b;
		stall <= hold || (jitter && (($random(seed) & 15) == 0));
		if ({a, b} !== {10'h155, 10'h2AA})
			exp_q.push_back(exp_word(a, b));
	endtask : send
	task automatic rnd(input int n);
		repeat (n) send(10'($random(seed)), 10'($random(seed)));
	endtask : rnd
	task automatic end_test(input string name);
		$display("test %s ended, %0d checks", name, num_checks);
	endtask : end_test
	// Clock at 50 MHz
	always #10 clk = ~clk;
	// Cycle ceiling cuts a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			test_done();
		end
	end
	// Match captured words in order; skipped expected words count as dropped
	always @(negedge clk)
		while (i_cap.rx_q.size() > 0)
		begin
			got = i_cap.rx_q.pop_front();
			if (got !== {10'h155, 10'h2AA})
			begin
				while (exp_q.size() > 0 && exp_q[0] !== got)
				begin
					void'(exp_q.pop_front());
					skips++;
				end
				`CHK(exp_q.size() > 0, 1'b1)
				if (exp_q.size() > 0)
					void'(exp_q.pop_front());
			end
		end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(res_i, RESULT_RST)
		`CHK(vld, 1'b0)
		repeat (17) send(10'h155, 10'h2AA);
		#1;
		`CHK(init_done, 1'b0)
		`CHK(vld, 1'b0)
		repeat (6) send(10'h155, 10'h2AA);
		#1;
		`CHK(init_done, 1'b1)
		end_test("init");
		send(10'h000, 10'h3FF);
		send(10'h3FF, 10'h000);
		send(10'h200, 10'h1FF);
		send(10'h1FF, 10'h200);
		send(10'h3C3, 10'h03C);
		for (int j = 1; j < 14; j++)
		begin
			rnd(1);
			#1;
			if (lat == 0 && res_i === 10'h3C3 && res_q === 10'h03C)
				lat = j;
		end
		`CHK(lat, LATENCY_CYC + 2)
		end_test("latency");
		s_low = 1'b0;
		jitter = 1'b1;
		rnd(150);
		jitter = 1'b0;
		rnd(20);
		`CHK(skips, 0)
		`CHK(s_low, 1'b0)
		end_test("stream");
		hold = 1'b1;
		rnd(60);
		hold = 1'b0;
		`CHK(s_low, 1'b1)
		rnd(80);
		`CHK(skips > 0, 1'b1)
		end_test("overflow");
		test_done();
	end
endmodule : dual_adc_path_tb
